// file: verilog/dti_pkg.sv
/*
  Package for the drive terminal I/O block: register map, reset values,
  output source codes and timing constants.
  Assumes a 200 MHz APB clock and 32-bit aligned register words.
*/
`default_nettype none
package dti_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_POLARITY = 8'h00;
  localparam logic [7:0] OFS_FILTER = 8'h04;
  localparam logic [7:0] OFS_VIRT_EN = 8'h08;
  localparam logic [7:0] OFS_WIRE_MODE = 8'h0C;
  localparam logic [7:0] OFS_ON_DELAY0 = 8'h10;
  localparam logic [7:0] OFS_OFF_DELAY0 = 8'h28;
  localparam logic [7:0] OFS_FAULT_STATE = 8'h40;
  localparam logic [7:0] OFS_LIVE_STATE = 8'h44;
  localparam logic [7:0] OFS_OUT_SEL0 = 8'h48;
  localparam logic [7:0] OFS_FAST_MODE = 8'h58;
  localparam logic [7:0] OFS_VIRT_IN = 8'h5C;
  localparam logic [7:0] OFS_COMM_OUT = 8'h60;
  localparam logic [7:0] OFS_OUT_STATE = 8'h64;
  // Field widths and reset values
  localparam int NUM_IN = 6;
  localparam int NUM_OUT = 4;
  localparam logic [5:0] POLARITY_RST = 6'h00;
  localparam logic [5:0] VIRT_EN_RST = 6'h00;
  localparam logic [15:0] FILTER_RST = 16'h000A;
  localparam logic [1:0] WIRE_MODE_RST = 2'h0;
  localparam logic [15:0] DELAY_RST = 16'h0000;
  localparam logic [15:0] DELAY_MAX = 16'hC350;
  localparam logic [15:0] FAULT_STATE_RST = 16'h0000;
  localparam logic [5:0] LIVE_STATE_RST = 6'h00;
  localparam logic [1:0] FAST_MODE_PULSE = 2'h0;
  localparam logic [5:0] SEL_RST_RELAY1 = 6'h01;
  localparam logic [5:0] SEL_RST_RELAY2 = 6'h05;
  localparam logic [5:0] SEL_RST_OTHER = 6'h00;
  // Output indexes
  localparam int OUT_OC = 0;
  localparam int OUT_FAST = 1;
  localparam int OUT_RELAY1 = 2;
  localparam int OUT_RELAY2 = 3;
  // Timing
  localparam int CLK_MHZ = 200;
  localparam int MS_US = 1000;
  localparam int MS_CYCLES = CLK_MHZ * MS_US;
  localparam int ZPULSE_MS = 10;
  // Output source codes
  localparam logic [5:0] SRC_NONE = 6'd0;
  localparam logic [5:0] SRC_RUN = 6'd1;
  localparam logic [5:0] SRC_FWD = 6'd2;
  localparam logic [5:0] SRC_REV = 6'd3;
  localparam logic [5:0] SRC_JOG = 6'd4;
  localparam logic [5:0] SRC_FAULT = 6'd5;
  localparam logic [5:0] SRC_ZERO_SPD = 6'd9;
  localparam logic [5:0] SRC_UPPER = 6'd10;
  localparam logic [5:0] SRC_LOWER = 6'd11;
  localparam logic [5:0] SRC_READY = 6'd12;
  localparam logic [5:0] SRC_PREEXC = 6'd13;
  localparam logic [5:0] SRC_OVLD = 6'd14;
  localparam logic [5:0] SRC_UNLD = 6'd15;
  localparam logic [5:0] SRC_STAGE = 6'd16;
  localparam logic [5:0] SRC_CYCLE = 6'd17;
  localparam logic [5:0] SRC_VIRT_A = 6'd23;
  localparam logic [5:0] SRC_VIRT_B = 6'd24;
  localparam logic [5:0] SRC_VIRT_C = 6'd25;
  localparam logic [5:0] SRC_DC_BUS = 6'd26;
  localparam logic [5:0] SRC_ZPULSE = 6'd27;
  localparam logic [5:0] SRC_SUPERPOS = 6'd28;
  localparam logic [5:0] SRC_STO = 6'd29;
  localparam logic [5:0] SRC_POS_DONE = 6'd30;
  localparam logic [5:0] SRC_SPZERO = 6'd31;
  localparam logic [5:0] SRC_SPDIV = 6'd32;
  localparam logic [5:0] SRC_SPD_LIM = 6'd33;
  localparam logic [5:0] SRC_VIRT_D = 6'd34;
endpackage : dti_pkg
`default_nettype wire

// file: verilog/dti_top.sv
/*
  Drive terminal I/O: six conditioned terminal inputs and four
  programmable outputs, registers on APB.
  Assumes terminal inputs and drive status flags synchronous to pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module dti_top (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Terminals
  input wire logic [5:0] term_in,
  output logic open_collector_output,
  output logic fast_pulse_output,
  output logic relay_output_1,
  output logic relay_output_2,
  output logic [1:0] wire_control_mode,
  output logic [5:0] input_state,
  // Drive status
  input wire logic st_running,
  input wire logic st_forward,
  input wire logic st_reverse,
  input wire logic st_jogging,
  input wire logic st_fault,
  input wire logic st_freq_zero,
  input wire logic st_ref_zero,
  input wire logic st_upper_lim,
  input wire logic st_lower_lim,
  input wire logic st_ready,
  input wire logic st_preexcite,
  input wire logic st_overload,
  input wire logic st_underload,
  input wire logic st_stage_done,
  input wire logic st_cycle_done,
  input wire logic st_dc_bus_ok,
  input wire logic st_index_pulse,
  input wire logic st_superpos,
  input wire logic st_safe_torque_off,
  input wire logic st_pos_done,
  input wire logic st_spindle_zero,
  input wire logic st_spindle_div,
  input wire logic st_speed_limit,
  input wire logic fast_pulse_train
);

  localparam int NUM_IN_L = dti_pkg::NUM_IN;
  localparam int NUM_OUT_L = dti_pkg::NUM_OUT;

  logic [5:0] polarity_reg;
  logic [15:0] filter_reg;
  logic [5:0] virt_en_reg;
  logic [5:0] virt_in_reg;
  logic [1:0] wire_mode_reg;
  logic [15:0] on_dly_reg [NUM_IN_L];
  logic [15:0] off_dly_reg [NUM_IN_L];
  logic [5:0] out_sel_reg [NUM_OUT_L];
  logic fast_mode_reg;
  logic [3:0] comm_out_reg;
  logic [15:0] fault_state_reg;
  logic [5:0] live_reg;
  logic fault_d_reg;
  logic [17:0] ms_cnt_reg;
  logic ms_tick;
  logic [5:0] filt_reg;
  logic [15:0] filt_cnt_reg [NUM_IN_L];
  logic [15:0] dly_cnt_reg [NUM_IN_L];
  logic [3:0] zp_cnt_reg;
  logic [NUM_OUT_L-1:0] out_next;
  logic [3:0] out_reg;
  logic wr_en;
  logic rd_en;
  logic [5:0] raw_in;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  // Millisecond tick for filter, delays and the index pulse stretch
  assign ms_tick = (ms_cnt_reg == 18'(dti_pkg::MS_CYCLES - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt_reg <= '0;
    end else if (ms_tick) begin
      ms_cnt_reg <= '0;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 18'd1;
    end
  end

  // Register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      polarity_reg <= dti_pkg::POLARITY_RST;
      filter_reg <= dti_pkg::FILTER_RST;
      virt_en_reg <= dti_pkg::VIRT_EN_RST;
      virt_in_reg <= '0;
      wire_mode_reg <= dti_pkg::WIRE_MODE_RST;
      fast_mode_reg <= dti_pkg::FAST_MODE_PULSE[0];
      comm_out_reg <= '0;
      for (int i = 0; i < NUM_IN_L; i++) begin
        on_dly_reg[i] <= dti_pkg::DELAY_RST;
        off_dly_reg[i] <= dti_pkg::DELAY_RST;
      end
      out_sel_reg[dti_pkg::OUT_OC] <= dti_pkg::SEL_RST_OTHER;
      out_sel_reg[dti_pkg::OUT_FAST] <= dti_pkg::SEL_RST_OTHER;
      out_sel_reg[dti_pkg::OUT_RELAY1] <= dti_pkg::SEL_RST_RELAY1;
      out_sel_reg[dti_pkg::OUT_RELAY2] <= dti_pkg::SEL_RST_RELAY2;
    end else if (wr_en) begin
      unique case (paddr)
        dti_pkg::OFS_POLARITY: polarity_reg <= pwdata[5:0];
        dti_pkg::OFS_FILTER: filter_reg <= pwdata[15:0];
        dti_pkg::OFS_VIRT_EN: virt_en_reg <= pwdata[5:0];
        dti_pkg::OFS_VIRT_IN: virt_in_reg <= pwdata[5:0];
        dti_pkg::OFS_WIRE_MODE: wire_mode_reg <= pwdata[1:0];
        dti_pkg::OFS_FAST_MODE: fast_mode_reg <= pwdata[0];
        dti_pkg::OFS_COMM_OUT: comm_out_reg <= pwdata[3:0];
        default: begin
          for (int i = 0; i < NUM_IN_L; i++) begin
            // Values above the documented range saturate
            if (paddr == dti_pkg::OFS_ON_DELAY0 + 8'(4 * i)) begin
              on_dly_reg[i] <= (pwdata[15:0] > dti_pkg::DELAY_MAX) ?
                dti_pkg::DELAY_MAX : pwdata[15:0];
            end
            if (paddr == dti_pkg::OFS_OFF_DELAY0 + 8'(4 * i)) begin
              off_dly_reg[i] <= (pwdata[15:0] > dti_pkg::DELAY_MAX) ?
                dti_pkg::DELAY_MAX : pwdata[15:0];
            end
          end
          for (int j = 0; j < NUM_OUT_L; j++) begin
            if (paddr == dti_pkg::OFS_OUT_SEL0 + 8'(4 * j)) begin
              out_sel_reg[j] <= pwdata[5:0];
            end
          end
        end
      endcase
    end
  end

  // Polarity, then virtual substitution ahead of the filter
  assign raw_in = ((term_in ^ polarity_reg) & ~virt_en_reg) |
                  (virt_in_reg & virt_en_reg);

  genvar g;
  generate
    for (g = 0; g < NUM_IN_L; g++) begin : g_in
      // Filter: the new level must persist for the filter time
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          filt_reg[g] <= 1'b0;
          filt_cnt_reg[g] <= '0;
        end else if (raw_in[g] == filt_reg[g]) begin
          filt_cnt_reg[g] <= '0;
        end else if (filt_cnt_reg[g] >= filter_reg) begin
          filt_reg[g] <= raw_in[g];
          filt_cnt_reg[g] <= '0;
        end else if (ms_tick) begin
          filt_cnt_reg[g] <= filt_cnt_reg[g] + 16'd1;
        end
      end
      // On and off delays; a reversal before expiry cancels the change
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          live_reg[g] <= dti_pkg::LIVE_STATE_RST[g];
          dly_cnt_reg[g] <= '0;
        end else if (filt_reg[g] == live_reg[g]) begin
          dly_cnt_reg[g] <= '0;
        end else if (dly_cnt_reg[g] >=
                     (filt_reg[g] ? on_dly_reg[g] : off_dly_reg[g])) begin
          live_reg[g] <= filt_reg[g];
          dly_cnt_reg[g] <= '0;
        end else if (ms_tick) begin
          dly_cnt_reg[g] <= dly_cnt_reg[g] + 16'd1;
        end
      end
    end
  endgenerate

  // Fault snapshot on the rising edge of the fault condition
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_d_reg <= 1'b0;
      fault_state_reg <= dti_pkg::FAULT_STATE_RST;
    end else begin
      fault_d_reg <= st_fault;
      if (st_fault && !fault_d_reg) begin
        fault_state_reg <= {10'h000, live_reg};
      end
    end
  end

  // Index pulse stretched to 10 ms; a new pulse restarts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zp_cnt_reg <= '0;
    end else if (st_index_pulse) begin
      zp_cnt_reg <= 4'(dti_pkg::ZPULSE_MS);
    end else if (ms_tick && zp_cnt_reg != 4'd0) begin
      zp_cnt_reg <= zp_cnt_reg - 4'd1;
    end
  end

  // Each output decodes its own code, so shared codes match exactly
  generate
    for (g = 0; g < NUM_OUT_L; g++) begin : g_out
      always_comb begin
        case (out_sel_reg[g])
          dti_pkg::SRC_NONE: out_next[g] = 1'b0;
          dti_pkg::SRC_RUN: out_next[g] = st_running;
          dti_pkg::SRC_FWD: out_next[g] = st_running && st_forward;
          dti_pkg::SRC_REV: out_next[g] = st_running && st_reverse;
          dti_pkg::SRC_JOG: out_next[g] = st_running && st_jogging;
          dti_pkg::SRC_FAULT: out_next[g] = st_fault;
          dti_pkg::SRC_ZERO_SPD:
            out_next[g] = st_freq_zero && st_ref_zero;
          dti_pkg::SRC_UPPER: out_next[g] = st_upper_lim;
          dti_pkg::SRC_LOWER: out_next[g] = st_lower_lim;
          dti_pkg::SRC_READY: out_next[g] = st_ready;
          dti_pkg::SRC_PREEXC: out_next[g] = st_preexcite;
          dti_pkg::SRC_OVLD: out_next[g] = st_overload;
          dti_pkg::SRC_UNLD: out_next[g] = st_underload;
          dti_pkg::SRC_STAGE: out_next[g] = st_stage_done;
          dti_pkg::SRC_CYCLE: out_next[g] = st_cycle_done;
          dti_pkg::SRC_VIRT_A: out_next[g] = comm_out_reg[0];
          dti_pkg::SRC_VIRT_B: out_next[g] = comm_out_reg[1];
          dti_pkg::SRC_VIRT_C: out_next[g] = comm_out_reg[2];
          dti_pkg::SRC_VIRT_D: out_next[g] = comm_out_reg[3];
          dti_pkg::SRC_DC_BUS: out_next[g] = st_dc_bus_ok;
          dti_pkg::SRC_ZPULSE: out_next[g] = (zp_cnt_reg != 4'd0);
          dti_pkg::SRC_SUPERPOS: out_next[g] = st_superpos;
          dti_pkg::SRC_STO: out_next[g] = st_safe_torque_off;
          dti_pkg::SRC_POS_DONE: out_next[g] = st_pos_done;
          dti_pkg::SRC_SPZERO: out_next[g] = st_spindle_zero;
          dti_pkg::SRC_SPDIV: out_next[g] = st_spindle_div;
          dti_pkg::SRC_SPD_LIM: out_next[g] = st_speed_limit;
          default: out_next[g] = 1'b0;
        endcase
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_reg <= '0;
      open_collector_output <= 1'b0;
      fast_pulse_output <= 1'b0;
      relay_output_1 <= 1'b0;
      relay_output_2 <= 1'b0;
    end else begin
      out_reg <= out_next;
      open_collector_output <= out_next[dti_pkg::OUT_OC];
      relay_output_1 <= out_next[dti_pkg::OUT_RELAY1];
      relay_output_2 <= out_next[dti_pkg::OUT_RELAY2];
      // Pulse mode passes the external pulse train generator through
      fast_pulse_output <= fast_mode_reg ? out_next[dti_pkg::OUT_FAST] :
                           fast_pulse_train;
    end
  end

  // Straight-from-flop copies of control state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wire_control_mode <= dti_pkg::WIRE_MODE_RST;
      input_state <= dti_pkg::LIVE_STATE_RST;
    end else begin
      wire_control_mode <= wire_mode_reg;
      input_state <= live_reg;
    end
  end

  // APB read: data prepared in setup, answered in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_en) begin
      prdata <= '0;
      unique case (paddr)
        dti_pkg::OFS_POLARITY: prdata <= {26'h0, polarity_reg};
        dti_pkg::OFS_FILTER: prdata <= {16'h0, filter_reg};
        dti_pkg::OFS_VIRT_EN: prdata <= {26'h0, virt_en_reg};
        dti_pkg::OFS_VIRT_IN: prdata <= {26'h0, virt_in_reg};
        dti_pkg::OFS_WIRE_MODE: prdata <= {30'h0, wire_mode_reg};
        dti_pkg::OFS_FAST_MODE: prdata <= {31'h0, fast_mode_reg};
        dti_pkg::OFS_COMM_OUT: prdata <= {28'h0, comm_out_reg};
        dti_pkg::OFS_FAULT_STATE: prdata <= {16'h0, fault_state_reg};
        dti_pkg::OFS_LIVE_STATE: prdata <= {26'h0, live_reg};
        dti_pkg::OFS_OUT_STATE: prdata <= {28'h0, out_reg};
        default: begin
          for (int i = 0; i < NUM_IN_L; i++) begin
            if (paddr == dti_pkg::OFS_ON_DELAY0 + 8'(4 * i)) begin
              prdata <= {16'h0, on_dly_reg[i]};
            end
            if (paddr == dti_pkg::OFS_OFF_DELAY0 + 8'(4 * i)) begin
              prdata <= {16'h0, off_dly_reg[i]};
            end
          end
          for (int j = 0; j < NUM_OUT_L; j++) begin
            if (paddr == dti_pkg::OFS_OUT_SEL0 + 8'(4 * j)) begin
              prdata <= {26'h0, out_sel_reg[j]};
            end
          end
        end
      endcase
    end
  end

  // Zero wait states; unmapped addresses read zero, never error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
    end
  end

endmodule : dti_top
`default_nettype wire

// file: sim/dti_top_asserts.sv
/*
  Checker for dti_top: APB answer timing and output source selection.
  Sees only top ports; select, mode and comm bits are shadowed from APB.
*/
`timescale 1ns/1ps
`default_nettype none
module dti_checker (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Outputs and sources
  input wire logic open_collector_output,
  input wire logic fast_pulse_output,
  input wire logic relay_output_1,
  input wire logic st_running,
  input wire logic st_freq_zero,
  input wire logic st_ref_zero,
  input wire logic st_index_pulse,
  input wire logic fast_pulse_train
);
  logic [5:0] sel_reg [4];
  logic fast_mode_reg;
  logic [3:0] comm_reg;
  logic wr_ok;
  logic oc_reserved;
  assign wr_ok = psel && penable && pwrite;
  assign oc_reserved = sel_reg[0] inside {6'd6, 6'd7, 6'd8, [6'd18:6'd22]}
    || sel_reg[0] > 6'd34;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_reg <= '{6'h00, 6'h00, dti_pkg::SEL_RST_RELAY1,
        dti_pkg::SEL_RST_RELAY2};
      fast_mode_reg <= 1'b0;
      comm_reg <= 4'h0;
    end else if (wr_ok) begin
      for (int j = 0; j < 4; j++) begin
        if (paddr == dti_pkg::OFS_OUT_SEL0 + 8'(4 * j)) begin
          sel_reg[j] <= pwdata[5:0];
        end
      end
      if (paddr == dti_pkg::OFS_FAST_MODE) begin
        fast_mode_reg <= pwdata[0];
      end
      if (paddr == dti_pkg::OFS_COMM_OUT) begin
        comm_reg <= pwdata[3:0];
      end
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_index_hit;
    sel_reg[0] == dti_pkg::SRC_ZPULSE && st_index_pulse;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> pready)
    else $error("pready missing in access cycle");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_no_slave_error: assert property (!pslverr)
    else $error("pslverr raised");
  a_code_zero_off: assert property (
    sel_reg[0] == dti_pkg::SRC_NONE |=> !open_collector_output)
    else $error("output on with code zero");
  a_run_follows: assert property (
    sel_reg[2] == dti_pkg::SRC_RUN |=> relay_output_1 == $past(st_running))
    else $error("relay does not follow running");
  a_zero_speed: assert property (sel_reg[0] == dti_pkg::SRC_ZERO_SPD |=>
    open_collector_output == ($past(st_freq_zero) && $past(st_ref_zero)))
    else $error("zero speed output wrong");
  a_same_source: assert property (sel_reg[0] == sel_reg[2] &&
    sel_reg[0] != dti_pkg::SRC_ZPULSE |=>
    open_collector_output == relay_output_1)
    else $error("outputs with same code differ");
  a_virtual_out: assert property (sel_reg[0] == dti_pkg::SRC_VIRT_A |=>
    open_collector_output == $past(comm_reg[0]))
    else $error("virtual output differs from comm bit");
  a_reserved_off: assert property (oc_reserved |=>
    !open_collector_output)
    else $error("output on with reserved code");
  a_pulse_mode: assert property (!fast_mode_reg |=>
    fast_pulse_output == $past(fast_pulse_train))
    else $error("fast output not following pulse train");
  a_index_stretch: assert property (
    s_index_hit |-> ##2 open_collector_output [*8])
    else $error("index pulse not stretched");
endmodule : dti_checker
bind dti_top dti_checker i_dti_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .open_collector_output(open_collector_output),
  .fast_pulse_output(fast_pulse_output), .relay_output_1(relay_output_1),
  .st_running(st_running), .st_freq_zero(st_freq_zero),
  .st_ref_zero(st_ref_zero), .st_index_pulse(st_index_pulse),
  .fast_pulse_train(fast_pulse_train));
`default_nettype wire

// file: sim/dti_field.sv
/*
  Field model: terminal contacts and the pulse train source.
  Assumes the bench commands contact levels on pclk edges.
*/
`timescale 1ns/1ps
`default_nettype none
module dti_field (
  // Bench command
  input wire logic pclk,
  input wire logic [5:0] contact,
  input wire logic train_en,
  // Terminal side
  output logic [5:0] term_in,
  output logic fast_pulse_train
);
  // Contacts settle one cycle after the command, like a real switch edge
  always @(posedge pclk) begin
    term_in <= contact;
    fast_pulse_train <= train_en ? !fast_pulse_train : 1'b0;
  end
endmodule : dti_field
`default_nettype wire

// file: sim/dti_top_bench.sv
/*
  Testbench for dti_top: APB register tests, input conditioning, outputs.
  Assumes the 200 MHz ms tick, so long delays are only seen as pending.
*/
`timescale 1ns/1ps
`default_nettype none
module dti_top_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic train_en = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, oc, fo, r1, r2, fast_train, t;
  logic [1:0] wmode;
  logic [5:0] term_in, in_st;
  logic [5:0] contact = 6'h00;
  logic [22:0] st = 23'h00_0000;
  int errors = 0;
  int checks_done = 0;
  int code_of [23] = '{1, 2, 3, 4, 5, 9, 9, 10, 11, 12, 13, 14, 15, 16, 17,
    26, 27, 28, 29, 30, 31, 32, 33};
  int vcode [4] = '{23, 24, 25, 34};
  int resv [6] = '{6, 7, 8, 21, 35, 63};
  always #2.5 pclk = ~pclk;
  dti_field i_dti_field (.pclk(pclk), .contact(contact),
    .train_en(train_en), .term_in(term_in), .fast_pulse_train(fast_train));
  dti_top i_dti_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .term_in(term_in),
    .open_collector_output(oc), .fast_pulse_output(fo),
    .relay_output_1(r1), .relay_output_2(r2), .wire_control_mode(wmode),
    .input_state(in_st), .st_running(st[0]), .st_forward(st[1]),
    .st_reverse(st[2]), .st_jogging(st[3]), .st_fault(st[4]),
    .st_freq_zero(st[5]), .st_ref_zero(st[6]), .st_upper_lim(st[7]),
    .st_lower_lim(st[8]), .st_ready(st[9]), .st_preexcite(st[10]),
    .st_overload(st[11]), .st_underload(st[12]), .st_stage_done(st[13]),
    .st_cycle_done(st[14]), .st_dc_bus_ok(st[15]),
    .st_index_pulse(st[16]), .st_superpos(st[17]),
    .st_safe_torque_off(st[18]), .st_pos_done(st[19]),
    .st_spindle_zero(st[20]), .st_spindle_div(st[21]),
    .st_speed_limit(st[22]), .fast_pulse_train(fast_train));
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  // One APB transfer, then one idle cycle so psel never toggles twice
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      errors++;
      tally_and_finish();
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input int d);
    apb(1'b1, a, 32'(d));
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, e);
  endtask : rdchk
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(dti_pkg::OFS_POLARITY, 32'(dti_pkg::POLARITY_RST));
    rdchk(dti_pkg::OFS_VIRT_EN, 32'(dti_pkg::VIRT_EN_RST));
    rdchk(dti_pkg::OFS_ON_DELAY0 + 8'h14, 32'(dti_pkg::DELAY_RST));
    rdchk(dti_pkg::OFS_OFF_DELAY0, 32'(dti_pkg::DELAY_RST));
    rdchk(dti_pkg::OFS_FAULT_STATE, 32'(dti_pkg::FAULT_STATE_RST));
    rdchk(dti_pkg::OFS_LIVE_STATE, 32'(dti_pkg::LIVE_STATE_RST));
    rdchk(dti_pkg::OFS_FAST_MODE, 32'(dti_pkg::FAST_MODE_PULSE));
    rdchk(8'hFC, 32'h0000_0000);
    wr(dti_pkg::OFS_POLARITY, 'hFF);
    rdchk(dti_pkg::OFS_POLARITY, 32'h0000_003F);
    wr(dti_pkg::OFS_ON_DELAY0, 'hFFFF);
    rdchk(dti_pkg::OFS_ON_DELAY0, 32'(dti_pkg::DELAY_MAX));
    wr(dti_pkg::OFS_ON_DELAY0, 0);
    wr(dti_pkg::OFS_WIRE_MODE, 3);
    rdchk(dti_pkg::OFS_WIRE_MODE, 32'h0000_0003);
    check(wmode, 32'h0000_0003);
    $display("Test registers done");
    wr(dti_pkg::OFS_FILTER, 0);
    wr(dti_pkg::OFS_POLARITY, 'h01);
    contact <= 6'h05;
    cyc(10);
    check(in_st, 32'h0000_0004);
    wr(dti_pkg::OFS_VIRT_IN, 'h02);
    wr(dti_pkg::OFS_VIRT_EN, 'h02);
    cyc(6);
    rdchk(dti_pkg::OFS_LIVE_STATE, 32'h0000_0006);
    wr(dti_pkg::OFS_VIRT_EN, 0);
    wr(dti_pkg::OFS_POLARITY, 0);
    cyc(6);
    st[4] <= 1'b1;
    cyc(3);
    check(r2, 32'h0000_0001);
    contact <= 6'h0A;
    cyc(10);
    rdchk(dti_pkg::OFS_FAULT_STATE, 32'h0000_0005);
    rdchk(dti_pkg::OFS_LIVE_STATE, 32'h0000_000A);
    st[4] <= 1'b0;
    cyc(3);
    check(r2, 32'h0000_0000);
    wr(dti_pkg::OFS_ON_DELAY0, 1);
    contact <= 6'h0B;
    cyc(50);
    check(in_st, 32'h0000_000A);
    wr(dti_pkg::OFS_OFF_DELAY0 + 8'h04, 1);
    contact <= 6'h09;
    cyc(50);
    check(in_st, 32'h0000_000A);
    $display("Test inputs done");
    for (int i = 0; i < 23; i++) begin
      if (i == 5 || i == 6 || i == 16) begin
        continue;
      end
      wr(dti_pkg::OFS_OUT_SEL0, code_of[i]);
      // Direction and jog codes only count while running
      st <= (23'(1) << i) | 23'(i inside {[1:3]});
      cyc(3);
      check(oc, 32'h0000_0001);
      // Index pulse kept low so the stretch test starts from idle
      st <= ~(23'(1) << i) & 23'h7E_FFFF;
      cyc(3);
      check(oc, 32'h0000_0000);
    end
    wr(dti_pkg::OFS_OUT_SEL0, 9);
    st <= 23'h00_0060;
    cyc(3);
    check(oc, 32'h0000_0001);
    st <= 23'h00_0020;
    cyc(3);
    check(oc, 32'h0000_0000);
    wr(dti_pkg::OFS_OUT_SEL0, 27);
    cyc(3);
    check(oc, 32'h0000_0000);
    st <= 23'h01_0000;
    cyc(1);
    st <= 23'h00_0000;
    cyc(100);
    check(oc, 32'h0000_0001);
    wr(dti_pkg::OFS_OUT_SEL0, 0);
    st <= 23'h7F_FFFF;
    cyc(3);
    check(oc, 32'h0000_0000);
    foreach (resv[k]) begin
      wr(dti_pkg::OFS_OUT_SEL0, resv[k]);
      cyc(3);
      check(oc, 32'h0000_0000);
    end
    st <= 23'h00_0000;
    for (int j = 0; j < 4; j++) begin
      wr(dti_pkg::OFS_COMM_OUT, 1 << j);
      wr(dti_pkg::OFS_OUT_SEL0, vcode[j]);
      cyc(3);
      check(oc, 32'h0000_0001);
      wr(dti_pkg::OFS_COMM_OUT, ~(1 << j) & 'hF);
      cyc(3);
      check(oc, 32'h0000_0000);
    end
    $display("Test output codes done");
    wr(dti_pkg::OFS_OUT_SEL0, 2);
    wr(dti_pkg::OFS_OUT_SEL0 + 8'h04, 2);
    wr(dti_pkg::OFS_OUT_SEL0 + 8'h08, 2);
    wr(dti_pkg::OFS_FAST_MODE, 1);
    st <= 23'h00_0003;
    cyc(3);
    check({oc, fo, r1}, 32'h0000_0007);
    rdchk(dti_pkg::OFS_OUT_STATE, 32'h0000_0007);
    wr(dti_pkg::OFS_FAST_MODE, 0);
    train_en <= 1'b1;
    cyc(3);
    t = fast_train;
    @(posedge pclk);
    check(fo, 32'(t));
    $display("Test shared and fast output done");
    tally_and_finish();
  end
endmodule : dti_top_bench
`default_nettype wire
